// *** design/keypad_cfg_regs.vh ***
// Offsets, field positions, reset values and timing counts of the keypad config bank
`ifndef KEYPAD_CFG_REGS_VH
`define KEYPAD_CFG_REGS_VH

// Register addresses on the register port
`define ADDR_DEBOUNCE        8'h02
`define ADDR_AUTOREPEAT      8'h05
`define ADDR_AUTOSLEEP       8'h06
`define ADDR_MATRIX_SIZE     8'h30
`define ADDR_LED_SELECT      8'h31

// Reset values
`define RST_DEBOUNCE         8'hff
`define RST_AUTOREPEAT       8'h00
`define RST_AUTOSLEEP        8'h07
`define RST_MATRIX_SIZE      8'hff
`define RST_LED_SELECT       8'h00

// Field positions
`define AR_ENABLE_BIT        7
`define AR_RATE_HI           6
`define AR_RATE_LO           4
`define AR_DELAY_HI          3
`define AR_DELAY_LO          0
`define SLEEP_CODE_HI        2
`define SLEEP_CODE_LO        0
`define ROWS_HI              7
`define ROWS_LO              4
`define COLS_HI              3
`define COLS_LO              0
`define LED_SEL_HI           3
`define LED_SEL_LO           0

// Writable masks; reserved bits read as zero
`define MASK_AUTOSLEEP       8'h07
`define MASK_LED_SELECT      8'h0f

// Timing
`define CLK_PERIOD_NS        4
`define DEBOUNCE_UNIT_MS     2
`define MS_CYCLES            (1000000 / `CLK_PERIOD_NS)
`define DELAY_STEP           8
`define RATE_STEP            4
`define SLEEP_MAX_MS         8192
`define SLEEP_MIN_MS         256

`endif

// *** design/repeat_timer.v ***
// Autorepeat delay and rate timer counted in debounce cycles
`timescale 1ns/100ps
`include "keypad_cfg_regs.vh"

module repeat_timer
(
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Configuration
   input  wire       enable,
   input  wire [3:0] delay_code,
   input  wire [2:0] rate_code,
   // Key and timing
   input  wire       key_held,
   input  wire       debounce_tick,
   // Result
   output reg        repeat_pulse
);

   reg  [7:0] count_ff;
   reg        started_ff;
   reg  [7:0] nxt_count;
   reg        nxt_started;
   reg        nxt_pulse;
   wire [7:0] delay_len;
   wire [7:0] rate_len;

   // Delay is 8*(code+1), rate is 4*(code+1)
   assign delay_len = ({4'h0, delay_code} + 8'h01) * 8'd`DELAY_STEP;
   assign rate_len  = ({5'h00, rate_code} + 8'h01) * 8'd`RATE_STEP;

   // Counting and repeat decision
   always @*
   begin
      nxt_count   = count_ff;
      nxt_started = started_ff;
      nxt_pulse   = 1'b0;
      if (!enable || !key_held)
      begin
         nxt_count   = 8'h00;
         nxt_started = 1'b0;
      end
      else if (debounce_tick)
      begin
         if (count_ff + 8'h01 >= (started_ff ? rate_len : delay_len))
         begin
            nxt_count   = 8'h00;
            nxt_started = 1'b1;
            nxt_pulse   = 1'b1;
         end
         else
            nxt_count = count_ff + 8'h01;
      end
   end

   // State registers
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         count_ff     <= 8'h00;
         started_ff   <= 1'b0;
         repeat_pulse <= 1'b0;
      end
      else
      begin
         count_ff     <= nxt_count;
         started_ff   <= nxt_started;
         repeat_pulse <= nxt_pulse;
      end
   end

endmodule // repeat_timer

// *** design/sleep_timer.v ***
// Autosleep inactivity timer
`timescale 1ns/100ps
`include "keypad_cfg_regs.vh"

module sleep_timer
#(
   parameter MS_CYCLES = `MS_CYCLES
)
(
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Configuration and activity
   input  wire [2:0] sleep_timeout_code,
   input  wire       activity,
   // Result
   output reg        sleep_req
);

   reg  [31:0] ms_ff;
   reg  [13:0] elapsed_ff;
   wire [13:0] limit;
   wire        ms_tick;

   // Timeout in ms from the 3-bit code
   function [13:0] sleep_ms;
      input [2:0] code;
      begin
         case (code)
            3'h1:    sleep_ms = 14'd`SLEEP_MAX_MS;
            3'h2:    sleep_ms = 14'd4096;
            3'h3:    sleep_ms = 14'd2048;
            3'h4:    sleep_ms = 14'd1024;
            3'h5:    sleep_ms = 14'd512;
            default: sleep_ms = 14'd`SLEEP_MIN_MS;
         endcase
      end
   endfunction

   assign limit   = sleep_ms(sleep_timeout_code);
   assign ms_tick = (ms_ff == MS_CYCLES - 1);

   // Millisecond prescaler and inactivity counter
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         ms_ff      <= 32'h0;
         elapsed_ff <= 14'h0;
         sleep_req  <= 1'b0;
      end
      else if (activity || sleep_timeout_code == 3'h0)
      begin
         ms_ff      <= 32'h0;
         elapsed_ff <= 14'h0;
         sleep_req  <= 1'b0;
      end
      else
      begin
         ms_ff <= ms_tick ? 32'h0 : ms_ff + 32'h1;
         if (ms_tick && elapsed_ff < limit)
            elapsed_ff <= elapsed_ff + 14'h1;
         sleep_req <= (elapsed_ff >= limit);
      end
   end

endmodule // sleep_timer

// *** design/keypad_scan_config_regs.v ***
// Keypad configuration register bank with autorepeat and autosleep timing
`timescale 1ns/100ps
`include "keypad_cfg_regs.vh"

module keypad_scan_config_regs
#(
   parameter MS_CYCLES = `MS_CYCLES
)
(
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Register port from the serial interface
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // Key activity
   input  wire       key_held,
   input  wire       key_event,
   // Scan and pin control
   output reg  [7:0] row_scan_en,
   output reg  [7:0] col_scan_en,
   output reg  [3:0] led_mode,
   output reg  [5:0] press_debounce_ms,
   output reg  [5:0] release_debounce_ms,
   // Timing results
   output wire       debounce_tick,
   output wire       repeat_pulse,
   output wire       sleep_req
);

   reg  [7:0]  debounce_ff;
   reg  [7:0]  autorepeat_ff;
   reg  [7:0]  autosleep_ff;
   reg  [7:0]  matrix_size_ff;
   reg  [7:0]  led_select_ff;
   reg  [31:0] deb_cnt_ff;
   reg  [5:0]  deb_ms_ff;
   reg  [7:0]  nxt_rdata;
   wire        deb_ms_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Line enable mask from a count code; bit 3 set means all eight
   function [7:0] line_mask;
      input [3:0] code;
      begin
         if (code[3])
            line_mask = 8'hff;
         else
            line_mask = (8'h01 << code[2:0]) - 8'h01;
      end
   endfunction

   // Debounce time in ms from a 4-bit code
   function [5:0] deb_ms;
      input [3:0] code;
      begin
         deb_ms = ({2'h0, code} + 6'h01) * 6'd`DEBOUNCE_UNIT_MS;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         debounce_ff    <= `RST_DEBOUNCE;
         autorepeat_ff  <= `RST_AUTOREPEAT;
         autosleep_ff   <= `RST_AUTOSLEEP;
         matrix_size_ff <= `RST_MATRIX_SIZE;
         led_select_ff  <= `RST_LED_SELECT;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `ADDR_DEBOUNCE:    debounce_ff    <= reg_wdata;
            `ADDR_AUTOREPEAT:  autorepeat_ff  <= reg_wdata;
            `ADDR_AUTOSLEEP:   autosleep_ff   <= reg_wdata & `MASK_AUTOSLEEP;
            `ADDR_MATRIX_SIZE: matrix_size_ff <= reg_wdata;
            `ADDR_LED_SELECT:  led_select_ff  <= reg_wdata & `MASK_LED_SELECT;
            default:           led_select_ff  <= led_select_ff;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always @*
   begin
      case (reg_addr)
         `ADDR_DEBOUNCE:    nxt_rdata = debounce_ff;
         `ADDR_AUTOREPEAT:  nxt_rdata = autorepeat_ff;
         `ADDR_AUTOSLEEP:   nxt_rdata = autosleep_ff;
         `ADDR_MATRIX_SIZE: nxt_rdata = matrix_size_ff;
         `ADDR_LED_SELECT:  nxt_rdata = led_select_ff;
         default:           nxt_rdata = 8'h00;
      endcase
   end

   // Registered read data, taken on reg_rd
   always @(posedge clk)
   begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= nxt_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded configuration outputs
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         row_scan_en         <= 8'hff;
         col_scan_en         <= 8'hff;
         led_mode            <= 4'h0;
         press_debounce_ms   <= 6'd32;
         release_debounce_ms <= 6'd32;
      end
      else
      begin
         row_scan_en         <= line_mask(matrix_size_ff[`ROWS_HI:`ROWS_LO]);
         col_scan_en         <= line_mask(matrix_size_ff[`COLS_HI:`COLS_LO]);
         led_mode            <= led_select_ff[`LED_SEL_HI:`LED_SEL_LO];
         press_debounce_ms   <= deb_ms(debounce_ff[3:0]);
         release_debounce_ms <= deb_ms(debounce_ff[7:4]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Debounce cycle generator, period equals press debounce time
   assign deb_ms_tick   = (deb_cnt_ff == MS_CYCLES - 1);
   assign debounce_tick = deb_ms_tick && (deb_ms_ff + 6'h01 >= deb_ms(debounce_ff[3:0]));

   always @(posedge clk)
   begin
      if (!nrst)
      begin
         deb_cnt_ff <= 32'h0;
         deb_ms_ff  <= 6'h00;
      end
      else
      begin
         deb_cnt_ff <= deb_ms_tick ? 32'h0 : deb_cnt_ff + 32'h1;
         if (debounce_tick)
            deb_ms_ff <= 6'h00;
         else if (deb_ms_tick)
            deb_ms_ff <= deb_ms_ff + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Autorepeat timer
   repeat_timer u_repeat
   (
      .clk           (clk),
      .nrst          (nrst),
      .enable        (autorepeat_ff[`AR_ENABLE_BIT]),
      .delay_code    (autorepeat_ff[`AR_DELAY_HI:`AR_DELAY_LO]),
      .rate_code     (autorepeat_ff[`AR_RATE_HI:`AR_RATE_LO]),
      .key_held      (key_held),
      .debounce_tick (debounce_tick),
      .repeat_pulse  (repeat_pulse)
   );

   // Autosleep timer
   sleep_timer #(.MS_CYCLES(MS_CYCLES)) u_sleep
   (
      .clk                (clk),
      .nrst               (nrst),
      .sleep_timeout_code (autosleep_ff[`SLEEP_CODE_HI:`SLEEP_CODE_LO]),
      .activity           (key_event | key_held | reg_wr),
      .sleep_req          (sleep_req)
   );

endmodule // keypad_scan_config_regs

// *** tb/keypad_cfg_monitor.sv ***
// Port checker for the keypad configuration bank
`timescale 1ns/100ps
module keypad_cfg_monitor
#(
   parameter MS_CYCLES = 4
)
(
   // Clock, reset and register port
   input wire       clk,
   input wire       nrst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   // Key activity and results
   input wire       key_held,
   input wire [7:0] row_scan_en,
   input wire [7:0] col_scan_en,
   input wire [3:0] led_mode,
   input wire [5:0] press_debounce_ms,
   input wire       debounce_tick,
   input wire       repeat_pulse,
   input wire       sleep_req
);
   reg       en_ff;
   // Line mask of a size code
   function [7:0] lines(input [3:0] c);
      lines = c[3] ? 8'hff : (8'h01 << c[2:0]) - 8'h01;
   endfunction
   // Autorepeat enable as last written
   always @(posedge clk)
   begin
      if (!nrst)
         en_ff <= 1'b0;
      else if (reg_wr && reg_addr == 8'h05)
         en_ff <= reg_wdata[7];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_reset_lines: assert property (disable iff (1'b0)
      !nrst |=> row_scan_en == 8'hff && col_scan_en == 8'hff && led_mode == 4'h0)
      else $error("reset values of line controls wrong");
   a_led_write: assert property (
      reg_wr && reg_addr == 8'h31 |-> ##2 led_mode == $past(reg_wdata[3:0], 2))
      else $error("led mode not taken from write");
   a_size_write: assert property (
      reg_wr && reg_addr == 8'h30 |-> ##2
      row_scan_en == lines($past(reg_wdata[7:4], 2)) &&
      col_scan_en == lines($past(reg_wdata[3:0], 2)))
      else $error("scan enables do not match size code");
   a_press_write: assert property (
      reg_wr && reg_addr == 8'h02 |-> ##2
      press_debounce_ms == {1'b0, $past(reg_wdata[3:0], 2), 1'b0} + 6'd2)
      else $error("press debounce time wrong");
   a_repeat_off: assert property (
      !en_ff && !$past(en_ff) |-> !repeat_pulse)
      else $error("repeat while disabled");
   a_repeat_cause: assert property (
      repeat_pulse |-> $past(debounce_tick) && $past(key_held))
      else $error("repeat without tick and held key");
   a_repeat_gap: assert property (
      repeat_pulse |=> !repeat_pulse [*3])
      else $error("repeats too close");
   a_sleep_rsvd: assert property (
      reg_rd && reg_addr == 8'h06 |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved sleep bits read nonzero");
   c_repeat: cover property (repeat_pulse);
   c_sleep: cover property ($rose(sleep_req));
   c_size: cover property (reg_wr && reg_addr == 8'h30);
endmodule // keypad_cfg_monitor

bind keypad_scan_config_regs keypad_cfg_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.clk, .nrst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .key_held, .row_scan_en,
   .col_scan_en, .led_mode, .press_debounce_ms, .debounce_tick, .repeat_pulse, .sleep_req);

// *** tb/host_model.sv ***
// Host model driving the register port
`timescale 1ns/100ps
module host_model
(
   // Clock
   input  wire       clk,
   // Register port
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_wr,
   output reg        reg_rd,
   input  wire [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One write strobe, reserved sleep bits kept zero
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= (a == 8'h06) ? (d & 8'h07) : d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   end
   endtask
   // One read strobe, data taken an edge later
   task rd(input [7:0] a, output [7:0] d);
   begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   end
   endtask
endmodule // host_model

// *** tb/keypad_scan_config_regs_tb.sv ***
// Testbench of the keypad configuration bank
`timescale 1ns/100ps
module keypad_scan_config_regs_tb;
   reg        clk, nrst, key_held, key_event;
   wire [7:0] reg_addr, reg_wdata, reg_rdata, row_scan_en, col_scan_en;
   wire       reg_wr, reg_rd, debounce_tick, repeat_pulse, sleep_req;
   wire [3:0] led_mode;
   wire [5:0] press_debounce_ms, release_debounce_ms;
   reg  [7:0] v;
   integer    err_total, n_compared, i, n;
   keypad_scan_config_regs #(.MS_CYCLES(4)) u_dut (.clk, .nrst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .key_held, .key_event, .row_scan_en, .col_scan_en,
      .led_mode, .press_debounce_ms, .release_debounce_ms, .debounce_tick, .repeat_pulse,
      .sleep_req);
   host_model u_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   ////////////////////////////////////////
   // Compare and report
   task chk(input string nm, input [7:0] e, input [7:0] g);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         err_total = err_total + 1;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task test_done;
   begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   // Write (register loads on its last edge), then two edges: decoded outputs, then a spare one
   task w(input [7:0] a, input [7:0] d);
   begin
      u_host.wr(a, d);
      repeat (2) @(posedge clk);
   end
   endtask
   task r(input [7:0] a, input [7:0] e);
   begin
      u_host.rd(a, v);
      chk("reg_rdata", e, v);
   end
   endtask
   // Debounce ticks until a repeat pulse
   task ticks;
      integer k;
   begin
      n = 0;
      for (k = 0; k < 3000 && repeat_pulse !== 1'b1; k++)
      begin
         @(posedge clk);
         n = n + (debounce_tick === 1'b1);
      end
   end
   endtask
   ////////////////////////////////////////
   // Scenarios
   task t_reset;
   begin
      r(8'h05, 8'h00);
      r(8'h06, 8'h07);
      r(8'h30, 8'hff);
      r(8'h31, 8'h00);
      r(8'h02, 8'hff);
      r(8'h07, 8'h00);
      chk("release", 8'd32, {2'b00, release_debounce_ms});
   end
   endtask
   task t_size;
   begin
      for (i = 0; i <= 8; i++)
      begin
         w(8'h30, {i[3:0], i[3:0]});
         v = (i == 8) ? 8'hff : (8'h01 << i) - 8'h01;
         chk("row_scan_en", v, row_scan_en);
         chk("col_scan_en", v, col_scan_en);
      end
   end
   endtask
   task t_led;
   begin
      w(8'h31, 8'hff);
      chk("led_mode", 8'h0f, {4'h0, led_mode});
      r(8'h31, 8'h0f);
      w(8'h07, 8'h55);
      w(8'h31, 8'h5a);
      chk("led_mode", 8'h0a, {4'h0, led_mode});
   end
   endtask
   task t_deb;
   begin
      w(8'h02, 8'h3c);
      chk("press", 8'd26, {2'b00, press_debounce_ms});
      chk("release", 8'd8, {2'b00, release_debounce_ms});
      w(8'h02, 8'h00);
      for (i = 0; i < 100 && debounce_tick !== 1'b1; i++)
         @(posedge clk);
      @(posedge clk);
      for (n = 1; n < 100 && debounce_tick !== 1'b1; n++)
         @(posedge clk);
      chk("tick_period", 8'd8, n[7:0]);
   end
   endtask
   task t_repeat;
   begin
      w(8'h05, 8'h91);
      key_held <= 1'b1;
      ticks;
      chk("first_delay", 8'd16, n[7:0]);
      @(posedge clk);
      ticks;
      chk("repeat_gap", 8'd8, n[7:0]);
      key_held <= 1'b0;
      w(8'h05, 8'h11);
      key_held <= 1'b1;
      for (i = 0; i < 400 && repeat_pulse !== 1'b1; i++)
         @(posedge clk);
      chk("disabled_repeat", 8'h00, {7'h00, repeat_pulse});
      key_held <= 1'b0;
   end
   endtask
   task t_sleep;
   begin
      w(8'h06, 8'h06);
      r(8'h06, 8'h06);
      repeat (990) @(posedge clk);
      chk("sleep_req", 8'h00, {7'h00, sleep_req});
      repeat (110) @(posedge clk);
      chk("sleep_req", 8'h01, {7'h00, sleep_req});
      key_event <= 1'b1;
      @(posedge clk);
      key_event <= 1'b0;
      repeat (8) @(posedge clk);
      chk("sleep_req", 8'h00, {7'h00, sleep_req});
      w(8'h06, 8'h00);
      repeat (1200) @(posedge clk);
      chk("sleep_req", 8'h00, {7'h00, sleep_req});
   end
   endtask
   ////////////////////////////////////////
   // Clock, watchdog and main sequence
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #100000;
      err_total = err_total + 1;
      test_done;
   end
   initial
   begin
      err_total = 0;
      n_compared = 0;
      nrst = 1'b0;
      key_held = 1'b0;
      key_event = 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_size;
      t_led;
      t_deb;
      t_repeat;
      t_sleep;
      test_done;
   end
endmodule // keypad_scan_config_regs_tb
